// ==== logic/ddio_cell_group.sv ====
`timescale 1ns/10ps
module ddio_cell_group #(
  parameter int LANE_BITS = ddio_pkg::LANE_BITS,
  parameter int BURST_PAIRS = ddio_pkg::BURST_PAIRS,
  parameter int DELAY_TAPS = ddio_pkg::DELAY_TAPS,
  parameter bit CELL_HALF = ddio_pkg::HALF_LEFT
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // reset, high; synchronous except for the strobe write pointer
  input wire logic strobe_clk, // delayed strobe, clocks the capture logic
  input wire logic strobe_pad, // raw strobe pad level
  input wire logic strobe_pad_driven, // high while the memory drives the strobe
  input wire logic [LANE_BITS-1:0] pad_data, // data pads of the lane
  input wire logic in_bypass, // route pads around registers and delay
  input wire logic [1:0] in_delay_sel, // input delay taps, 0 means none
  input wire logic ddr_in_mode, // high for strobe capture, low for single rate
  input wire logic read_start, // pulse, a read is being issued
  input wire logic [ddio_pkg::CAL_WIDTH-1:0] cal_left, // calibration from left loop
  input wire logic [ddio_pkg::CAL_WIDTH-1:0] cal_right, // calibration from right loop
  input wire logic route_clk, // routing clock for the output cell
  input wire logic clk_from_strobe, // cell clock from the strobe bus
  input wire logic clk_invert, // invert the chosen cell clock
  input wire logic cell_ce_route, // clock enable from routing
  input wire logic ce_invert, // invert the clock enable
  input wire logic cell_rst_route, // local reset from routing
  input wire logic rst_invert, // invert the local reset
  input wire logic global_tristate, // forces the pad off
  input wire logic ddr_out_mode, // double rate output and tristate
  input wire logic sdr_latch_mode, // single rate element acts as a latch
  input wire logic out_data_neg_phase, // output data, negative phase
  input wire logic out_data_pos_phase, // output data, positive phase
  input wire logic tri_ctrl_neg_phase, // tristate control, negative phase
  input wire logic tri_ctrl_pos_phase, // tristate control, positive phase
  output logic [LANE_BITS-1:0] direct_comb_input, // bypassed pad data
  output logic direct_clock_input, // bypassed pad used as clock
  output logic strobe_delay_input, // strobe into the delay element
  output logic local_strobe_bus, // strobe shared by the data cells
  output logic [ddio_pkg::CAL_WIDTH-1:0] strobe_delay_setting, // delay setting
  output logic [LANE_BITS-1:0] sdr_data, // single rate captured data
  output logic [LANE_BITS-1:0] first_capture_stream, // rising strobe data
  output logic [LANE_BITS-1:0] second_capture_stream, // falling strobe data
  output logic capture_valid, // pulse, a pair reached the core
  output logic sync_clock_polarity, // 1 selects inverted clock for sync
  output logic read_active, // polarity chosen, burst in flight
  output logic preamble_timeout, // pulse, no preamble seen in time
  output logic pad_out, // pad output data
  output logic pad_out_en_n // low while the pad is driven
);
  localparam int PW = $clog2(BURST_PAIRS) + 1;
  localparam int IW = $clog2(BURST_PAIRS);

  if (LANE_BITS > ddio_pkg::DATA_CELLS || LANE_BITS < 1) begin : g_bad_lane
    $error("lane width does not fit the strobe group");
  end
  if (BURST_PAIRS < 2 || (BURST_PAIRS & (BURST_PAIRS - 1)) != 0) begin : g_bad_burst
    $error("burst length must be a power of two, at least two");
  end
  if (DELAY_TAPS < 1 || DELAY_TAPS > 3) begin : g_bad_taps
    $error("delay taps must be 1 to 3");
  end

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // control selection
  wire logic cell_clk = (clk_from_strobe ? strobe_clk : route_clk) ^ clk_invert; // see RULE16
  wire logic cell_ce = cell_ce_route ^ ce_invert; // see RULE17
  wire logic cell_rst = cell_rst_route ^ rst_invert; // see RULE17

  // bypass paths
  assign direct_comb_input = in_bypass ? pad_data : '0; // see RULE3
  assign direct_clock_input = in_bypass & pad_data[0]; // see RULE3
  assign strobe_delay_input = strobe_pad; // see RULE3
  assign local_strobe_bus = strobe_clk; // see RULE1

  // calibration of this group's strobe delay
  wire logic [ddio_pkg::CAL_WIDTH-1:0] cal_own = (CELL_HALF == ddio_pkg::HALF_RIGHT) ? cal_right : cal_left;
  always_ff @(posedge clk) begin
    strobe_delay_setting <= sys_rst ? '0 : cal_own; // see RULE18 RULE19
  end

  // pad input synchroniser, value taken once stages two and three agree
  logic [LANE_BITS-1:0] pin_s1, pin_s2, pin_s3, pin_stable;
  logic [1:0] ctl_s1, ctl_s2, ctl_s3, ctl_stable;
  always_ff @(posedge clk) begin
    pin_s1 <= pad_data;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
    ctl_s1 <= {strobe_pad_driven, strobe_pad};
    ctl_s2 <= ctl_s1;
    ctl_s3 <= ctl_s2;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_stable <= '0;
      ctl_stable <= 2'b01;
    end else begin
      for (int i = 0; i < LANE_BITS; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_stable[i] <= pin_s3[i];
        end
      end
      for (int i = 0; i < 2; i++) begin
        if (ctl_s2[i] == ctl_s3[i]) begin
          ctl_stable[i] <= ctl_s3[i];
        end
      end
    end
  end

  // optional delay stage
  logic [LANE_BITS-1:0] dly [DELAY_TAPS];
  always_ff @(posedge clk) begin
    dly[0] <= pin_stable; // see RULE4
    for (int i = 1; i < DELAY_TAPS; i++) begin
      dly[i] <= dly[i-1];
    end
  end
  wire logic [1:0] tap_sel = (in_delay_sel > 2'(DELAY_TAPS)) ? 2'(DELAY_TAPS) : in_delay_sel;
  wire logic [LANE_BITS-1:0] delayed_in = (tap_sel == 2'h0) ? pin_stable : dly[tap_sel - 2'h1]; // see RULE4

  // single rate capture
  wire logic sdr_load = !in_bypass && !ddr_in_mode && cell_ce;
  always_ff @(posedge clk) begin
    if (sys_rst || cell_rst) begin
      sdr_data <= '0; // see RULE8
    end else if (sdr_load) begin
      sdr_data <= delayed_in; // see RULE5
    end
  end

  // strobe domain capture store, pointer advances on the falling edge
  logic [LANE_BITS-1:0] store_first [BURST_PAIRS];
  logic [LANE_BITS-1:0] store_second [BURST_PAIRS];
  logic [PW-1:0] wbin, wgray;
  wire logic [IW-1:0] widx = wbin[IW-1:0];
  wire logic [PW-1:0] next_wbin = wbin + 1'b1;
  always_ff @(posedge strobe_clk) begin
    store_first[widx] <= pad_data; // see RULE6
  end
  always_ff @(negedge strobe_clk) begin
    store_second[widx] <= pad_data; // see RULE6
  end
  // the strobe stands still during reset, so the pointer clears without it
  always_ff @(negedge strobe_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wbin <= '0;
      wgray <= '0;
    end else begin
      wbin <= next_wbin;
      wgray <= next_wbin ^ (next_wbin >> 1);
    end
  end

  // write pointer crossing into the system clock domain
  logic [PW-1:0] wg_s1, wg_s2, wg_s3, wg_seen;
  always_ff @(posedge clk) begin
    wg_s1 <= wgray;
    wg_s2 <= wg_s1;
    wg_s3 <= wg_s2;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wg_seen <= '0;
    end else if (wg_s2 == wg_s3) begin
      wg_seen <= wg_s3;
    end
  end
  wire logic [PW-1:0] wbin_seen = gray2bin(wg_seen);

  // read sequencing and polarity choice
  ddio_pkg::ddio_rd_state_type state, next_state;
  logic [PW-1:0] rptr;
  logic [IW-1:0] pair_cnt;
  logic [ddio_pkg::WAIT_W-1:0] wait_cnt;
  logic drv_prev;
  wire logic avail = rptr != wbin_seen;
  wire logic xfer = (state == ddio_pkg::DDIO_HOLD) && avail && cell_ce && ddr_in_mode;
  wire logic last_pair = pair_cnt == IW'(BURST_PAIRS - 1);
  wire logic preamble_hit = (state == ddio_pkg::DDIO_ARMED) && !drv_prev && ctl_stable[1]
                            && !ctl_stable[0]; // see RULE23
  wire logic wait_over = wait_cnt == ddio_pkg::WAIT_W'(ddio_pkg::PREAMBLE_WAIT_CYC);

  always_comb begin
    next_state = state;
    case (state)
      ddio_pkg::DDIO_IDLE: begin
        if (read_start) next_state = ddio_pkg::DDIO_ARMED;
      end
      ddio_pkg::DDIO_ARMED: begin
        if (read_start) next_state = ddio_pkg::DDIO_ARMED;
        else if (preamble_hit) next_state = ddio_pkg::DDIO_HOLD;
        else if (wait_over) next_state = ddio_pkg::DDIO_IDLE;
      end
      ddio_pkg::DDIO_HOLD: begin
        if (read_start) next_state = ddio_pkg::DDIO_ARMED; // see RULE21
        else if (xfer && last_pair) next_state = ddio_pkg::DDIO_IDLE; // see RULE24
      end
      default: next_state = ddio_pkg::DDIO_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ddio_pkg::DDIO_IDLE;
      drv_prev <= 1'b0;
      wait_cnt <= '0;
      sync_clock_polarity <= 1'b0;
      preamble_timeout <= 1'b0;
    end else begin
      state <= next_state;
      drv_prev <= ctl_stable[1];
      preamble_timeout <= (state == ddio_pkg::DDIO_ARMED) && !read_start && !preamble_hit && wait_over;
      if (read_start) begin
        wait_cnt <= '0;
        sync_clock_polarity <= 1'b0; // see RULE21
      end else begin
        if (state == ddio_pkg::DDIO_ARMED && !wait_over) begin
          wait_cnt <= wait_cnt + 1'b1;
        end
        if (preamble_hit) begin
          // the clock phase at which the preamble lands picks the safe edge
          sync_clock_polarity <= wait_cnt[0]; // see RULE20 RULE23
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || read_start) begin
      rptr <= wbin_seen; // stale pairs are dropped
      pair_cnt <= '0;
    end else if (xfer) begin
      rptr <= rptr + 1'b1;
      pair_cnt <= pair_cnt + 1'b1;
    end
  end

  // sync registers: an inverted clock stage ahead of the true edge when chosen
  wire logic [IW-1:0] ridx = rptr[IW-1:0];
  logic [LANE_BITS-1:0] neg_first, neg_second;
  always_ff @(negedge clk) begin
    neg_first <= store_first[ridx]; // see RULE9
    neg_second <= store_second[ridx]; // see RULE9
  end
  wire logic [LANE_BITS-1:0] sel_first = sync_clock_polarity ? neg_first : store_first[ridx];
  wire logic [LANE_BITS-1:0] sel_second = sync_clock_polarity ? neg_second : store_second[ridx];
  always_ff @(posedge clk) begin
    if (sys_rst || cell_rst) begin
      first_capture_stream <= '0; // see RULE8
      second_capture_stream <= '0;
      capture_valid <= 1'b0;
    end else begin
      capture_valid <= xfer;
      if (xfer) begin
        first_capture_stream <= sel_first; // see RULE7
        second_capture_stream <= sel_second; // see RULE7
      end
    end
  end
  always_ff @(posedge clk) begin
    read_active <= !sys_rst && (next_state == ddio_pkg::DDIO_HOLD);
  end

  // output and tristate paths: lane 0 data, lane 1 tristate control
  wire logic [1:0] neg_in = {tri_ctrl_neg_phase, out_data_neg_phase};
  wire logic [1:0] pos_in = {tri_ctrl_pos_phase, out_data_pos_phase};
  logic [1:0] path_out;
  for (genvar k = 0; k < 2; k++) begin : g_path
    logic edge_q, sdr_lat, ddr_lat;
    always_ff @(posedge cell_clk) begin
      if (cell_rst) begin
        edge_q <= 1'b0; // see RULE13
      end else if (cell_ce || ddr_out_mode) begin
        edge_q <= neg_in[k]; // see RULE10 RULE11 RULE14 RULE15
      end
    end
    always_latch begin
      if (cell_rst) begin
        sdr_lat = 1'b0;
      end else if (cell_clk && cell_ce) begin
        sdr_lat = neg_in[k]; // see RULE10 RULE14
      end
    end
    always_latch begin
      if (!cell_clk) begin
        ddr_lat = pos_in[k]; // see RULE12 RULE13
      end
    end
    wire logic sdr_val = sdr_latch_mode ? sdr_lat : edge_q;
    wire logic ddr_val = cell_clk ? edge_q : ddr_lat; // see RULE11 RULE15
    assign path_out[k] = ddr_out_mode ? ddr_val : sdr_val;
  end
  assign pad_out = path_out[0];
  assign pad_out_en_n = path_out[1] | global_tristate; // see RULE14 RULE17

  // checks
  property p_start_clears;
    @(posedge clk) disable iff (sys_rst)
    read_start |=> state == ddio_pkg::DDIO_ARMED && !sync_clock_polarity && !read_active;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("read start kept the old polarity"); // see RULE21

  sequence s_preamble;
    preamble_hit && !read_start;
  endsequence
  sequence s_choose;
    state == ddio_pkg::DDIO_HOLD && read_active;
  endsequence
  property p_preamble_sets;
    @(posedge clk) disable iff (sys_rst)
    s_preamble |=> s_choose and (sync_clock_polarity == $past(wait_cnt[0]));
  endproperty
  a_preamble_sets: assert property (p_preamble_sets) else $error("preamble did not set polarity"); // see RULE23

  property p_pol_stable;
    @(posedge clk) disable iff (sys_rst)
    state == ddio_pkg::DDIO_HOLD && !read_start |=> $stable(sync_clock_polarity);
  endproperty
  a_pol_stable: assert property (p_pol_stable) else $error("polarity moved during a burst"); // see RULE24

  property p_burst_end;
    @(posedge clk) disable iff (sys_rst)
    xfer && last_pair && !read_start |=> state == ddio_pkg::DDIO_IDLE ##1 !read_active || read_start;
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst end did not release polarity"); // see RULE24

  property p_xfer_data;
    @(posedge clk) disable iff (sys_rst || cell_rst)
    xfer |=> capture_valid && first_capture_stream == $past(sel_first)
             && second_capture_stream == $past(sel_second);
  endproperty
  a_xfer_data: assert property (p_xfer_data) else $error("pair not re-registered"); // see RULE7

  property p_sdr_hold;
    @(posedge clk) disable iff (sys_rst)
    !cell_rst && !sdr_load |=> $stable(sdr_data);
  endproperty
  a_sdr_hold: assert property (p_sdr_hold) else $error("single rate data moved without enable"); // see RULE8

  property p_sdr_path;
    @(posedge clk) disable iff (sys_rst)
    !cell_rst && sdr_load && tap_sel == 2'h0 |=> sdr_data == $past(pin_stable);
  endproperty
  a_sdr_path: assert property (p_sdr_path) else $error("single rate capture wrong"); // see RULE5

  property p_bypass;
    @(posedge clk) disable iff (sys_rst)
    in_bypass |-> direct_comb_input == pad_data && direct_clock_input == pad_data[0];
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass path wrong"); // see RULE3

  property p_cal_half;
    @(posedge clk) disable iff (sys_rst)
    1'b1 |=> strobe_delay_setting == $past((CELL_HALF == ddio_pkg::HALF_RIGHT) ? cal_right : cal_left);
  endproperty
  a_cal_half: assert property (p_cal_half) else $error("calibration from the wrong half"); // see RULE19

  property p_timeout;
    @(posedge clk) disable iff (sys_rst)
    state == ddio_pkg::DDIO_ARMED && !read_start && !preamble_hit && wait_over
      |=> preamble_timeout && state == ddio_pkg::DDIO_IDLE ##1 !preamble_timeout;
  endproperty
  a_timeout: assert property (p_timeout) else $error("preamble wait not ended"); // see RULE23

  property p_pair_step;
    @(negedge strobe_clk) disable iff (sys_rst)
    1'b1 |=> wbin == $past(wbin) + 1'b1;
  endproperty
  a_pair_step: assert property (p_pair_step) else $error("strobe pair not counted"); // see RULE6

  property p_out_hold;
    @(posedge cell_clk) disable iff (cell_rst)
    !cell_ce && !ddr_out_mode |=> $stable(g_path[0].edge_q);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output element ignored enable"); // see RULE13

  property p_gts;
    @(posedge clk) disable iff (sys_rst)
    global_tristate |-> pad_out_en_n;
  endproperty
  a_gts: assert property (p_gts) else $error("global tristate did not release pad"); // see RULE17
endmodule

// ==== logic/ddio_pkg.sv ====
// What this block does
// RULE1 - one strobe cell per group of 14 drives a strobe bus shared by 13 cells
// RULE2 - memory gives one strobe per eight data bits, one byte lane per bus
// RULE3 - pad input can bypass registers and delay: combinational, clock, strobe delay input
// RULE4 - without bypass, input passes an optional configurable delay before the registers
// RULE5 - single rate input is captured by one sync register on the system clock
// RULE6 - double rate input samples on rising and falling strobe edges, two streams
// RULE7 - both strobe streams are re-registered on the system clock before the core
// RULE8 - single rate and sync input registers have reset and clock enable
// RULE9 - polarity input picks true or inverted system clock for the sync registers
// RULE10 - single rate output uses one element, flip-flop or latch, to drive the pad
// RULE11 - double rate output: neg data on rising edge, pos data latched, clock mux
// RULE12 - the extra double rate output latch is transparent while its clock is low
// RULE13 - single rate output has reset and enable; extra double rate latch has neither
// RULE14 - single rate tristate passes neg control through flip-flop or latch to enable
// RULE15 - double rate tristate: neg control on rising edge, pos latched, clock mux
// RULE16 - cell clock from routing clock or strobe bus, optionally inverted
// RULE17 - clock enable and local reset from routing with inversion; global tristate passes
// RULE18 - strobe delay set by a 6-bit calibration bus from two loops on opposite sides
// RULE19 - each calibration loop drives only the strobe delays in its own half
// RULE20 - polarity picks the sync edge so strobe to system clock transfer is safe
// RULE21 - polarity is re-evaluated at the start of every read, never carried over
// RULE22 - memory leaves strobe undriven before a read and drives it low at preamble
// RULE23 - logic detects undriven to low strobe transition and sets the polarity from it
// RULE24 - chosen polarity stays stable until the burst has fully reached the system clock
package ddio_pkg;
  localparam int GROUP_CELLS = 14;
  localparam int DATA_CELLS = 13;
  localparam int LANE_BITS = 8;
  localparam int CAL_WIDTH = 6;
  localparam int BURST_PAIRS = 4;
  localparam int DELAY_TAPS = 3;
  localparam int CLK_MHZ = 10;
  // longest wait for the preamble after a read is started
  localparam int PREAMBLE_WAIT_NS = 2000;
  localparam int PREAMBLE_WAIT_CYC = (PREAMBLE_WAIT_NS * CLK_MHZ) / 1000;
  localparam int WAIT_W = 8;
  localparam bit HALF_LEFT = 1'b0;
  localparam bit HALF_RIGHT = 1'b1;

  typedef enum logic [1:0] {
    DDIO_IDLE = 2'b00,
    DDIO_ARMED = 2'b01,
    DDIO_HOLD = 2'b11
  } ddio_rd_state_type;
endpackage

// ==== test/ddio_mem_model.sv ====
`timescale 1ns/10ps
module ddio_mem_model (
  input wire logic go, // start a read burst
  input wire logic slow, // stretch the gap between strobe pairs
  input wire logic [7:0] base, // first data byte of the burst
  output logic strobe_clk, // delayed strobe, still outside bursts
  output logic strobe_pad, // raw strobe level
  output logic strobe_pad_driven, // high while the strobe is driven
  output logic [7:0] dq, // data lane
  output logic busy // high while the burst owns the lane
);
  int i;
  initial begin
    strobe_clk = 1'b0;
    strobe_pad = 1'b1;
    strobe_pad_driven = 1'b0;
    dq = 8'h00;
    busy = 1'b0;
  end
  // strobe undriven before a read, pulled high by termination
  always @(posedge go) begin
    busy = 1'b1;
    #213;
    strobe_pad = 1'b0;
    strobe_pad_driven = 1'b1;
    #800;
    for (i = 0; i < ddio_pkg::BURST_PAIRS; i++) begin
      dq = base + 8'(2 * i);
      #20;
      strobe_clk = 1'b1;
      strobe_pad = 1'b1;
      #20;
      dq = base + 8'(2 * i + 1);
      #20;
      strobe_clk = 1'b0;
      strobe_pad = 1'b0;
      #20;
      if (slow) begin
        #160;
      end
    end
    #40;
    strobe_pad_driven = 1'b0;
    strobe_pad = 1'b1;
    // released lane shows the inverse of its last value
    dq = ~dq;
    busy = 1'b0;
  end
endmodule

// ==== test/ddr_capable_io_register_cell_test.sv ====
`timescale 1ns/10ps
module ddr_capable_io_register_cell_test;
  logic clk, sys_rst, in_bypass, ddr_in_mode, read_start, route_clk, clk_from_strobe, clk_invert;
  logic cell_ce_route, ce_invert, cell_rst_route, rst_invert, global_tristate, ddr_out_mode, sdr_latch_mode;
  logic out_data_neg_phase, out_data_pos_phase, tri_ctrl_neg_phase, tri_ctrl_pos_phase;
  logic [1:0] in_delay_sel;
  logic [5:0] cal_left, cal_right;
  logic [7:0] tb_data, m_base, m_dq, pad, direct_comb_input, sdr_data, first_capture_stream, second_capture_stream;
  logic m_go, m_slow, m_busy, strobe_clk, strobe_pad, strobe_pad_driven, direct_clock_input, strobe_delay_input;
  logic local_strobe_bus, capture_valid, sync_clock_polarity, read_active, preamble_timeout, pad_out, pad_out_en_n;
  logic [5:0] strobe_delay_setting;
  int fails = 0;
  int n_compared = 0;
  assign pad = m_busy ? m_dq : tb_data;
  ddio_mem_model mem (.go(m_go), .slow(m_slow), .base(m_base), .strobe_clk(strobe_clk), .strobe_pad(strobe_pad),
    .strobe_pad_driven(strobe_pad_driven), .dq(m_dq), .busy(m_busy));
  ddio_cell_group dut (.clk(clk), .sys_rst(sys_rst), .strobe_clk(strobe_clk), .strobe_pad(strobe_pad),
    .strobe_pad_driven(strobe_pad_driven), .pad_data(pad), .in_bypass(in_bypass), .in_delay_sel(in_delay_sel),
    .ddr_in_mode(ddr_in_mode), .read_start(read_start), .cal_left(cal_left), .cal_right(cal_right),
    .route_clk(route_clk), .clk_from_strobe(clk_from_strobe), .clk_invert(clk_invert),
    .cell_ce_route(cell_ce_route), .ce_invert(ce_invert), .cell_rst_route(cell_rst_route), .rst_invert(rst_invert),
    .global_tristate(global_tristate), .ddr_out_mode(ddr_out_mode), .sdr_latch_mode(sdr_latch_mode),
    .out_data_neg_phase(out_data_neg_phase), .out_data_pos_phase(out_data_pos_phase),
    .tri_ctrl_neg_phase(tri_ctrl_neg_phase), .tri_ctrl_pos_phase(tri_ctrl_pos_phase),
    .direct_comb_input(direct_comb_input), .direct_clock_input(direct_clock_input),
    .strobe_delay_input(strobe_delay_input), .local_strobe_bus(local_strobe_bus),
    .strobe_delay_setting(strobe_delay_setting), .sdr_data(sdr_data), .first_capture_stream(first_capture_stream),
    .second_capture_stream(second_capture_stream), .capture_valid(capture_valid),
    .sync_clock_polarity(sync_clock_polarity), .read_active(read_active), .preamble_timeout(preamble_timeout),
    .pad_out(pad_out), .pad_out_en_n(pad_out_en_n));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (fails == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rc(input logic v);
    @(negedge clk);
    route_clk = v;
    #5;
  endtask
  // cycles from a pad change until single rate data shows it
  task automatic lat(input logic [7:0] v, output int n);
    @(negedge clk);
    tb_data = v;
    n = 0;
    while (sdr_data !== v && n < 20) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic t_bypass_cal;
    in_bypass = 1'b1;
    tb_data = 8'h81;
    cal_left = 6'h2a;
    cal_right = 6'h15;
    tick(3);
    chk(direct_comb_input, 8'h81);
    chk(direct_clock_input, 1'b1);
    chk(strobe_delay_input, 1'b1);
    chk(local_strobe_bus, 1'b0);
    chk(strobe_delay_setting, 6'h2a);
    cal_left = 6'h3f;
    in_bypass = 1'b0;
    tick(3);
    chk(strobe_delay_setting, 6'h3f);
    chk(direct_comb_input, 8'h00);
  endtask
  task automatic t_sdr_in;
    int n0;
    int n2;
    lat(8'h5a, n0);
    in_delay_sel = 2'h2;
    lat(8'ha5, n2);
    chk(8'(n2 - n0), 8'h02);
    chk(sdr_data, 8'ha5);
    cell_ce_route = 1'b0;
    tb_data = 8'h3c;
    tick(10);
    chk(sdr_data, 8'ha5);
    cell_ce_route = 1'b1;
    ddr_in_mode = 1'b1;
    tick(10);
    chk(sdr_data, 8'ha5);
    ddr_in_mode = 1'b0;
    cell_rst_route = 1'b1;
    tick(3);
    chk(sdr_data, 8'h00);
    cell_rst_route = 1'b0;
  endtask
  task automatic t_read(input logic s, input logic [7:0] b);
    int k;
    int n;
    logic pol;
    m_slow = s;
    m_base = b;
    ddr_in_mode = 1'b1;
    @(negedge clk);
    read_start = 1'b1;
    m_go = 1'b1;
    @(negedge clk);
    read_start = 1'b0;
    m_go = 1'b0;
    for (k = 0; k < ddio_pkg::BURST_PAIRS; k++) begin
      n = 0;
      while (capture_valid !== 1'b1 && n < 80) begin
        @(negedge clk);
        n++;
      end
      chk(capture_valid, 1'b1);
      chk(first_capture_stream, b + 8'(2 * k));
      chk(second_capture_stream, b + 8'(2 * k + 1));
      chk(read_active, 8'(k < ddio_pkg::BURST_PAIRS - 1));
      if (k == 0) begin
        pol = sync_clock_polarity;
      end
      chk(sync_clock_polarity, pol);
      @(negedge clk);
    end
    tick(10);
    chk(read_active, 1'b0);
  endtask
  task automatic t_timeout;
    int n;
    @(negedge clk);
    read_start = 1'b1;
    @(negedge clk);
    read_start = 1'b0;
    n = 0;
    while (preamble_timeout !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(preamble_timeout, 1'b1);
    chk(read_active, 1'b0);
    chk(sync_clock_polarity, 1'b0);
  endtask
  task automatic t_out;
    ddr_out_mode = 1'b1;
    out_data_neg_phase = 1'b1;
    tri_ctrl_pos_phase = 1'b1;
    rc(1'b1);
    chk(pad_out, 1'b1);
    chk(pad_out_en_n, 1'b0);
    rc(1'b0);
    chk(pad_out, 1'b0);
    chk(pad_out_en_n, 1'b1);
    out_data_pos_phase = 1'b1;
    #5;
    chk(pad_out, 1'b1);
    out_data_neg_phase = 1'b0;
    cell_ce_route = 1'b0;
    cell_rst_route = 1'b1;
    rc(1'b1);
    chk(pad_out, 1'b0);
    rc(1'b0);
    chk(pad_out, 1'b1);
    tri_ctrl_pos_phase = 1'b0;
    #5;
    chk(pad_out_en_n, 1'b0);
    global_tristate = 1'b1;
    #5;
    chk(pad_out_en_n, 1'b1);
    global_tristate = 1'b0;
    cell_rst_route = 1'b0;
    ddr_out_mode = 1'b0;
    ce_invert = 1'b1;
    out_data_neg_phase = 1'b1;
    tri_ctrl_neg_phase = 1'b1;
    rc(1'b1);
    chk(pad_out, 1'b1);
    chk(pad_out_en_n, 1'b1);
    out_data_neg_phase = 1'b0;
    ce_invert = 1'b0;
    rc(1'b0);
    rc(1'b1);
    chk(pad_out, 1'b1);
    cell_ce_route = 1'b1;
    rst_invert = 1'b1;
    rc(1'b0);
    rc(1'b1);
    chk(pad_out, 1'b0);
    rst_invert = 1'b0;
    out_data_neg_phase = 1'b1;
    clk_invert = 1'b1;
    rc(1'b0);
    chk(pad_out, 1'b1);
    clk_from_strobe = 1'b1;
    out_data_neg_phase = 1'b0;
    rc(1'b1);
    rc(1'b0);
    chk(pad_out, 1'b1);
    clk_from_strobe = 1'b0;
    clk_invert = 1'b0;
    sdr_latch_mode = 1'b1;
    rc(1'b1);
    out_data_neg_phase = 1'b1;
    #5;
    chk(pad_out, 1'b1);
    rc(1'b0);
    out_data_neg_phase = 1'b0;
    #5;
    chk(pad_out, 1'b1);
  endtask
  initial begin
    {sys_rst, cell_ce_route} = 2'b11;
    {in_bypass, ddr_in_mode, read_start, route_clk, clk_from_strobe, clk_invert, ce_invert} = 7'h00;
    {cell_rst_route, rst_invert, global_tristate, ddr_out_mode, sdr_latch_mode} = 5'h00;
    {out_data_neg_phase, out_data_pos_phase, tri_ctrl_neg_phase, tri_ctrl_pos_phase, m_go, m_slow} = 6'h00;
    {in_delay_sel, cal_left, cal_right, tb_data, m_base} = 30'h0;
    tick(16);
    sys_rst = 1'b0;
    tick(5);
    t_bypass_cal();
    t_sdr_in();
    t_read(1'b0, 8'h10);
    t_read(1'b1, 8'hc8);
    t_timeout();
    t_out();
    end_of_test();
  end
  initial begin
    #500000;
    fails++;
    end_of_test();
  end
endmodule
